//--- verilog/pwm_gen_pkg.sv
// constants for the pwm generator control block
package pwm_gen_pkg;
   // register word offsets on the plain port
   localparam logic [2:0]  CTRL_ADDR    = 3'h0;
   localparam logic [2:0]  DUTY_ADDR    = 3'h1;
   localparam logic [2:0]  PHASE_ADDR   = 3'h2;
   localparam logic [2:0]  MASTER_ADDR  = 3'h3;
   localparam logic [2:0]  STATUS_ADDR  = 3'h4;
   localparam logic [2:0]  MASK_ADDR    = 3'h5;
   localparam logic [2:0]  ACTIVE_ADDR  = 3'h6;
   // control field positions
   localparam int          CL_PEND_BIT  = 14;
   localparam int          TRG_PEND_BIT = 13;
   localparam int          CL_IEN_BIT   = 11;
   localparam int          TRG_IEN_BIT  = 10;
   localparam int          ITB_BIT      = 9;
   localparam int          DUTY_SOURCE_SELECT_BIT     = 8;
   localparam int          DTC_LSB      = 6;
   localparam int          XRES_BIT     = 1;
   localparam int          IUE_BIT      = 0;
   // writable control bits: 11..6, 1, 0
   localparam logic [15:0] CTRL_WMASK   = 16'h0FC3;
   localparam logic [15:0] CTRL_RESET   = 16'h0000;
   localparam logic [1:0]  DTC_RESERVED = 2'h3;
   localparam logic [1:0]  DTC_POSITIVE = 2'h0;
   // phase register keeps bits 15..2
   localparam logic [15:0] PHASE_WMASK  = 16'hFFFC;
   localparam logic [15:0] PHASE_RESET  = 16'h0000;
   localparam logic [15:0] DUTY_RESET   = 16'h0000;
   localparam logic [15:0] DUTY_MIN     = 16'h0008;
   localparam logic [15:0] DUTY_MAX     = 16'hFFEF;
   // interrupt status and mask layout
   localparam int          IRQ_CL_BIT   = 0;
   localparam int          IRQ_TRG_BIT  = 1;
   localparam logic [1:0]  IRQ_RESET    = 2'h0;
endpackage : pwm_gen_pkg

//--- verilog/period_counter.sv
// independent time base: counts 0..period and pulses on wrap
module period_counter #(
   parameter int W = 16
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         clear,
   input  wire logic [W-1:0] period,
   output logic      [W-1:0] count_q,
   output logic              wrap_q
);
   // a one-bit counter could not hold a useful period
   if (W < 2) begin : g_width_check
      $error("period_counter: W must be at least 2");
   end

   // clear wins over counting so a limit event restarts the period
   always_ff @(posedge ref_clk) begin
      if (!rst_n || clear) begin
         count_q <= '0;
         wrap_q  <= 1'b0;
      end else if (count_q >= period) begin
         count_q <= '0;
         wrap_q  <= 1'b1;
      end else begin
         count_q <= count_q + W'(1);
         wrap_q  <= 1'b0;
      end
   end
endmodule : period_counter

//--- verilog/pwm_generator_control.sv
// one pwm generator: control, duty selection, update timing, interrupts
// Summary of operation
// - current-limit enable gates the limit interrupt; off clears its pending flag
// - trigger enable gates trigger interrupts; off holds trigger pending clear
// - independent select takes period from phase register, else primary base
// - duty-source select picks master duty, else generator's own duty
// - dead-time field: 00 positive, 01 negative, 10 off, 11 reserved
// - control bits 5 to 2 read as zero
// - external reset with independent base: current limit restarts the base
// - external reset off: no pin touches the time base
// - immediate update on: duty writes reach the comparator at once
// - immediate update off: duty changes wait for the time base
// - sixteen-bit read/write duty value, reset to zero
// - phase register bits 15..2 read/write, reset zero; offset or period; here used only as the independent-base period, never as an offset
// - master duty register holds a shared sixteen-bit duty value
//
// Implementation choices: the address-and-strobe port and the address map.
module pwm_generator_control #(
   parameter int W = 16
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [2:0]   reg_addr,
   input  wire logic [15:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   input  wire logic [W-1:0] primary_count,
   input  wire logic         primary_period_end,
   input  wire logic         current_limit_in,
   input  wire logic         trigger_in,
   output logic      [15:0]  reg_rdata_q,
   output logic              pwm_out_q,
   output logic      [1:0]   dead_time_mode_q,
   output logic              period_end_q,
   output logic              irq_q
);
   // the register file is sixteen bits wide
   if (W != 16) begin : g_width_check
      $error("pwm_generator_control: W must be 16");
   end

   logic [15:0]  ctrl_q;
   logic [15:0]  ctrl_d;
   logic [15:0]  duty_q;
   logic [15:0]  phase_q;
   logic [15:0]  master_q;
   logic [15:0]  active_q;
   logic [1:0]   status_q;
   logic [1:0]   status_d;
   logic [1:0]   mask_q;
   logic [W-1:0] ind_count;
   logic         ind_wrap;
   logic         tb_clear;
   logic [W-1:0] sel_count;
   logic         boundary;
   logic [15:0]  duty_src;
   logic         cl_ien;
   logic         trg_ien;
   logic         independent_timebase_select;
   logic         duty_source_select;
   logic         immediate_update_enable;
   logic         xres;

   // write strobe decode, shared by every register but the read-only active duty
   function automatic logic wr_hit(input logic [2:0] a);
      return reg_wr && (reg_addr == a);
   endfunction : wr_hit

   assign cl_ien  = ctrl_q[pwm_gen_pkg::CL_IEN_BIT];
   assign trg_ien = ctrl_q[pwm_gen_pkg::TRG_IEN_BIT];
   assign independent_timebase_select     = ctrl_q[pwm_gen_pkg::ITB_BIT];
   assign duty_source_select    = ctrl_q[pwm_gen_pkg::DUTY_SOURCE_SELECT_BIT];
   assign immediate_update_enable     = ctrl_q[pwm_gen_pkg::IUE_BIT];
   assign xres    = ctrl_q[pwm_gen_pkg::XRES_BIT];

   // control write; a reserved dead-time code keeps the old mode
   always_comb begin
      ctrl_d = reg_wdata & pwm_gen_pkg::CTRL_WMASK;
      if (reg_wdata[pwm_gen_pkg::DTC_LSB +: 2] == pwm_gen_pkg::DTC_RESERVED) begin
         ctrl_d[pwm_gen_pkg::DTC_LSB +: 2] = ctrl_q[pwm_gen_pkg::DTC_LSB +: 2];
      end
   end

   // control register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= pwm_gen_pkg::CTRL_RESET;
      end else if (wr_hit(pwm_gen_pkg::CTRL_ADDR)) begin
         ctrl_q <= ctrl_d;
      end
   end

   // generator duty register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         duty_q <= pwm_gen_pkg::DUTY_RESET;
      end else if (wr_hit(pwm_gen_pkg::DUTY_ADDR)) begin
         duty_q <= reg_wdata;
      end
   end

   // master duty register, shared source
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         master_q <= pwm_gen_pkg::DUTY_RESET;
      end else if (wr_hit(pwm_gen_pkg::MASTER_ADDR)) begin
         master_q <= reg_wdata;
      end
   end

   // phase register; low two bits are not kept
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phase_q <= pwm_gen_pkg::PHASE_RESET;
      end else if (wr_hit(pwm_gen_pkg::PHASE_ADDR)) begin
         phase_q <= reg_wdata & pwm_gen_pkg::PHASE_WMASK;
      end
   end

   // interrupt mask register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mask_q <= pwm_gen_pkg::IRQ_RESET;
      end else if (wr_hit(pwm_gen_pkg::MASK_ADDR)) begin
         mask_q <= reg_wdata[1:0];
      end
   end

   // sticky flags: set beats a write-one clear, enable off forces clear
   always_comb begin
      status_d = status_q;
      if (wr_hit(pwm_gen_pkg::STATUS_ADDR)) begin
         status_d = status_q & ~reg_wdata[1:0];
      end
      if (current_limit_in) begin
         status_d[pwm_gen_pkg::IRQ_CL_BIT] = 1'b1;
      end
      if (trigger_in) begin
         status_d[pwm_gen_pkg::IRQ_TRG_BIT] = 1'b1;
      end
      if (!cl_ien) begin
         status_d[pwm_gen_pkg::IRQ_CL_BIT] = 1'b0;
      end
      if (!trg_ien) begin
         status_d[pwm_gen_pkg::IRQ_TRG_BIT] = 1'b0;
      end
   end

   // pending flags
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         status_q <= pwm_gen_pkg::IRQ_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // level interrupt; registered so the pin never glitches
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   // the limit input restarts only an independent base, and only if allowed
   assign tb_clear = xres && independent_timebase_select && current_limit_in;

   period_counter #(
      .W (W)
   ) u_period_counter (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clear   (tb_clear),
      .period  (phase_q),
      .count_q (ind_count),
      .wrap_q  (ind_wrap)
   );

   // time base and duty source selection
   assign sel_count = independent_timebase_select ? ind_count : primary_count;
   assign boundary  = independent_timebase_select ? ind_wrap : primary_period_end;
   assign duty_src  = duty_source_select ? master_q : duty_q;

   // active duty: follows the source at once, or only on a boundary
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         active_q <= pwm_gen_pkg::DUTY_RESET;
      end else if (immediate_update_enable) begin
         active_q <= duty_src;
      end else if (boundary) begin
         active_q <= duty_src;
      end
   end

   // comparator; duty below the floor is not guarded, software keeps range
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pwm_out_q <= 1'b0;
      end else begin
         pwm_out_q <= sel_count < active_q;
      end
   end

   // period boundary and dead-time mode out to the output stage
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         period_end_q     <= 1'b0;
         dead_time_mode_q <= pwm_gen_pkg::DTC_POSITIVE;
      end else begin
         period_end_q     <= boundary;
         dead_time_mode_q <= ctrl_q[pwm_gen_pkg::DTC_LSB +: 2];
      end
   end

   // read port: data only in the cycle after the strobe, unmapped reads zero
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !reg_rd) begin
         reg_rdata_q <= 16'h0000;
      end else begin
         case (reg_addr)
            pwm_gen_pkg::CTRL_ADDR: begin
               reg_rdata_q <= ctrl_q;
               reg_rdata_q[pwm_gen_pkg::CL_PEND_BIT] <=
                  status_q[pwm_gen_pkg::IRQ_CL_BIT];
               reg_rdata_q[pwm_gen_pkg::TRG_PEND_BIT] <=
                  status_q[pwm_gen_pkg::IRQ_TRG_BIT];
            end
            pwm_gen_pkg::DUTY_ADDR: begin
               reg_rdata_q <= duty_q;
            end
            pwm_gen_pkg::PHASE_ADDR: begin
               reg_rdata_q <= phase_q;
            end
            pwm_gen_pkg::MASTER_ADDR: begin
               reg_rdata_q <= master_q;
            end
            pwm_gen_pkg::STATUS_ADDR: begin
               reg_rdata_q <= {14'h0000, status_q};
            end
            pwm_gen_pkg::MASK_ADDR: begin
               reg_rdata_q <= {14'h0000, mask_q};
            end
            pwm_gen_pkg::ACTIVE_ADDR: begin
               reg_rdata_q <= active_q;
            end
            default: begin
               reg_rdata_q <= 16'h0000;
            end
         endcase
      end
   end

   // checks on the logic above
   // strobes written out so the checks see sampled values, not post-edge ones
   sequence s_duty_write;
      reg_wr && reg_addr == pwm_gen_pkg::DUTY_ADDR;
   endsequence

   sequence s_own_immediate;
      immediate_update_enable && !duty_source_select && !(reg_wr && reg_addr == pwm_gen_pkg::CTRL_ADDR);
   endsequence

   a_cl_forced_clear: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !cl_ien |=> !status_q[pwm_gen_pkg::IRQ_CL_BIT])
      else $error("limit pending set while its enable is off");

   a_cl_pending_set: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      current_limit_in && cl_ien |=> status_q[pwm_gen_pkg::IRQ_CL_BIT])
      else $error("limit event lost");

   a_trg_forced_clear: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !trg_ien |=> !status_q[pwm_gen_pkg::IRQ_TRG_BIT])
      else $error("trigger pending set while its enable is off");

   a_trg_pending_set: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trigger_in && trg_ien |=> status_q[pwm_gen_pkg::IRQ_TRG_BIT] ##1
         (irq_q || !$past(mask_q[1])))
      else $error("trigger event lost or interrupt missing");

   a_dead_time_legal: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      dead_time_mode_q != pwm_gen_pkg::DTC_RESERVED)
      else $error("reserved dead-time mode reached the output");

   a_ctrl_unused_zero: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == pwm_gen_pkg::CTRL_ADDR |=> reg_rdata_q[5:2] == 4'h0)
      else $error("unused control bits read nonzero");

   a_ext_reset_base: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      xres && independent_timebase_select && current_limit_in |=> ind_count == '0 ##1 ind_count <= W'(1))
      else $error("limit did not restart independent base");

   a_no_ext_reset: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !xres && ind_count < phase_q |=> ind_count == $past(ind_count) + W'(1))
      else $error("time base disturbed with external reset off");

   a_immediate_update: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      s_duty_write ##1 s_own_immediate |=> active_q == $past(reg_wdata, 2))
      else $error("immediate duty write not applied");

   a_sync_hold: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !immediate_update_enable && !boundary |=> $stable(active_q))
      else $error("active duty changed off a boundary");

   a_sync_load: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !immediate_update_enable && boundary |=> active_q == $past(duty_src))
      else $error("boundary did not load new duty");

   a_master_select: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      immediate_update_enable && duty_source_select |=> active_q == $past(master_q))
      else $error("master duty not selected");
endmodule : pwm_generator_control

//--- dv/switching_stage_model.sv
// behavioural power switching stage: follows pwm, reports overload as current limit
module switching_stage_model (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        pwm_in,
   input  wire logic [1:0]  dead_mode,
   input  wire logic        overload_req,
   output logic             current_limit,
   output logic [15:0]      on_count_q,
   output logic             reserved_seen_q
);
   timeunit 1ns;
   timeprecision 1ps;

   // comparator on the sense resistor, no filtering delay
   assign current_limit = overload_req;

   // switch on-time tally, only to show the stage is driven
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         on_count_q <= 16'h0000;
      end else if (pwm_in) begin
         on_count_q <= on_count_q + 16'h0001;
      end
   end

   // a reserved dead-time code must never reach the stage
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reserved_seen_q <= 1'b0;
      end else if (dead_mode == 2'h3) begin
         reserved_seen_q <= 1'b1;
      end
   end
endmodule : switching_stage_model

//--- dv/pwm_generator_control_tb_top.sv
// self-checking bench for one pwm generator control block
module pwm_generator_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic [2:0]  a;
      logic [15:0] w;
      logic [15:0] r;
      logic [1:0]  m;
   } row_type;

   logic        ref_clk, rst_n, reg_wr, reg_rd, primary_period_end;
   logic        trigger_in, overload, current_limit_in, pwm_out_q, period_end_q, irq_q;
   logic        reserved_seen;
   logic [2:0]  reg_addr;
   logic [15:0] reg_wdata, primary_count, reg_rdata_q, on_count;
   logic [1:0]  dead_time_mode_q;
   int          bad_count, check_count, k;

   // writes of the same register read back through the mask of implemented bits
   row_type rows [10] = '{
      '{3'h0, 16'h0CBE, 16'h0C82, 2'h2}, '{3'h0, 16'hFFFE, 16'h0F82, 2'h2},
      '{3'h0, 16'h0040, 16'h0040, 2'h1}, '{3'h0, 16'h0000, 16'h0000, 2'h0},
      '{3'h1, 16'hFFEF, 16'hFFEF, 2'h0}, '{3'h1, 16'h0008, 16'h0008, 2'h0},
      '{3'h2, 16'hABCF, 16'hABCC, 2'h0}, '{3'h3, 16'h1234, 16'h1234, 2'h0},
      '{3'h7, 16'hFFFF, 16'h0000, 2'h0}, '{3'h6, 16'hFFFF, 16'h0000, 2'h0}};

   pwm_generator_control dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .primary_count(primary_count),
      .primary_period_end(primary_period_end), .current_limit_in(current_limit_in),
      .trigger_in(trigger_in), .reg_rdata_q(reg_rdata_q), .pwm_out_q(pwm_out_q),
      .dead_time_mode_q(dead_time_mode_q), .period_end_q(period_end_q), .irq_q(irq_q));

   switching_stage_model stage_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .pwm_in(pwm_out_q), .dead_mode(dead_time_mode_q),
      .overload_req(overload), .current_limit(current_limit_in), .on_count_q(on_count),
      .reserved_seen_q(reserved_seen));

   // 40 MHz reference
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic test_done;
      if (bad_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t word got %h expected %h", $time, got, exp);
      end
   endtask : chk16

   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t flag got %b expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : idle

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 chk16(reg_rdata_q, exp);
   endtask : rd

   // one-cycle event: limit through the stage model, or trigger
   task automatic ev(input bit limit);
      @(posedge ref_clk);
      if (limit) overload <= 1'b1;
      else trigger_in <= 1'b1;
      @(posedge ref_clk);
      overload   <= 1'b0;
      trigger_in <= 1'b0;
      idle(3);
   endtask : ev

   // counts period boundary pulses over n cycles with limit held as given
   task automatic count_pe(input int n, input logic cl);
      @(posedge ref_clk);
      overload <= cl;
      k = 0;
      repeat (n) begin
         @(posedge ref_clk);
         if (period_end_q === 1'b1) k++;
      end
      overload <= 1'b0;
   endtask : count_pe

   // hang guard, far beyond the expected run
   initial begin
      #200us;
      bad_count++;
      test_done();
   end

   initial begin
      {rst_n, reg_wr, reg_rd, primary_period_end, trigger_in, overload} = '0;
      reg_addr = 3'h0; reg_wdata = 16'h0000; primary_count = 16'h0000;
      bad_count = 0; check_count = 0;
      idle(2);
      rst_n <= 1'b1;
      #1 chk1(irq_q, 1'b0);
      for (int i = 0; i < 7; i++) rd(i[2:0], 16'h0000);
      // ordinary register rows; duty values kept in range
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].r);
         chk16({14'h0000, dead_time_mode_q}, {14'h0000, rows[i].m});
      end
      // interrupts: raise, mask, clear, enable off
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0C00);
      wr(pwm_gen_pkg::MASK_ADDR, 16'h0003);
      ev(1'b1);
      rd(pwm_gen_pkg::STATUS_ADDR, 16'h0001);
      chk1(irq_q, 1'b1);
      rd(pwm_gen_pkg::CTRL_ADDR, 16'h4C00);
      ev(1'b0);
      rd(pwm_gen_pkg::STATUS_ADDR, 16'h0003);
      wr(pwm_gen_pkg::MASK_ADDR, 16'h0002);
      wr(pwm_gen_pkg::STATUS_ADDR, 16'h0002);
      idle(2);
      #1 chk1(irq_q, 1'b0);
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0400);
      rd(pwm_gen_pkg::STATUS_ADDR, 16'h0000);
      ev(1'b1);
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0000);
      ev(1'b0);
      rd(pwm_gen_pkg::STATUS_ADDR, 16'h0000);
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0C00);
      ev(1'b0);
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0800);
      rd(pwm_gen_pkg::STATUS_ADDR, 16'h0000);
      // limit flag cleared by writing a one while its enable stays on
      ev(1'b1);
      rd(pwm_gen_pkg::STATUS_ADDR, 16'h0001);
      wr(pwm_gen_pkg::STATUS_ADDR, 16'h0001);
      rd(pwm_gen_pkg::STATUS_ADDR, 16'h0000);
      // immediate update, own then master duty
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0001);
      wr(pwm_gen_pkg::DUTY_ADDR, 16'h0100);
      rd(pwm_gen_pkg::ACTIVE_ADDR, 16'h0100);
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0101);
      rd(pwm_gen_pkg::ACTIVE_ADDR, 16'h1234);
      primary_count <= 16'h0050;
      idle(3);
      #1 chk1(pwm_out_q, 1'b1);
      primary_count <= 16'h2000;
      idle(3);
      #1 chk1(pwm_out_q, 1'b0);
      // synchronized update waits for the primary boundary
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0000);
      wr(pwm_gen_pkg::DUTY_ADDR, 16'h0200);
      idle(3);
      rd(pwm_gen_pkg::ACTIVE_ADDR, 16'h1234);
      @(posedge ref_clk) primary_period_end <= 1'b1;
      @(posedge ref_clk) primary_period_end <= 1'b0;
      rd(pwm_gen_pkg::ACTIVE_ADDR, 16'h0200);
      // independent base from phase 0x0010: boundary every 17 cycles
      wr(pwm_gen_pkg::PHASE_ADDR, 16'h0010);
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0200);
      wr(pwm_gen_pkg::DUTY_ADDR, 16'h0300);
      count_pe(40, 1'b0);
      rd(pwm_gen_pkg::ACTIVE_ADDR, 16'h0300);
      chk16(k[15:0], 16'h0002);
      count_pe(20, 1'b1);
      chk1(k != 0, 1'b1);
      wr(pwm_gen_pkg::CTRL_ADDR, 16'h0202);
      count_pe(40, 1'b1);
      chk16(k[15:0], 16'h0000);
      chk1(on_count != 16'h0000, 1'b1);
      chk1(reserved_seen, 1'b0);
      // second reset in mid-run returns the registers to zero
      @(posedge ref_clk) rst_n <= 1'b0;
      idle(2);
      rst_n <= 1'b1;
      rd(pwm_gen_pkg::CTRL_ADDR, 16'h0000);
      rd(pwm_gen_pkg::ACTIVE_ADDR, 16'h0000);
      rd(pwm_gen_pkg::PHASE_ADDR, 16'h0000);
      chk16({14'h0000, dead_time_mode_q}, 16'h0000);
      test_done();
   end
endmodule : pwm_generator_control_tb_top
